// file: logic/ioc_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "ioc_params.svh"
module ioc_port (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] pin_direction,
  input wire logic [7:0] input_inversion,
  input wire logic [7:0] change_irq_enable,
  input wire logic [7:0] default_compare_value,
  input wire logic [7:0] compare_mode_select,
  input wire logic [7:0] expander_config,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup,
  output logic irq_out,
  output logic irq_oe
);
  ioc_pkg::ioc_byte_t pullup_enable;
  ioc_pkg::ioc_byte_t interrupt_flags;
  ioc_pkg::ioc_byte_t interrupt_capture;
  ioc_pkg::ioc_byte_t output_latch;
  ioc_pkg::ioc_byte_t reference;
  ioc_pkg::ioc_byte_t pin_sync;
  logic irq_pending;

  ioc_sync u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  wire [7:0] is_input = pin_direction;
  wire [7:0] port_level_bits = pin_sync ^ input_inversion;
  wire [7:0] compare_ref = (compare_mode_select & default_compare_value) |
    (~compare_mode_select & reference);
  wire [7:0] condition = (pin_sync ^ compare_ref) & change_irq_enable & is_input;
  wire any_condition = |condition;
  wire clear_read = reg_rd && ((reg_addr == `IOC_ADDR_CAPTURE) ||
    (reg_addr == `IOC_ADDR_PORT));
  wire new_irq = any_condition && !irq_pending;
  wire wr_pullup = reg_wr && (reg_addr == `IOC_ADDR_PULLUP);
  wire wr_latch = reg_wr && ((reg_addr == `IOC_ADDR_PORT) ||
    (reg_addr == `IOC_ADDR_LATCH));
  wire open_drain = expander_config[`IOC_CFG_OPEN_DRAIN];
  wire active_high = expander_config[`IOC_CFG_ACTIVE_HIGH];

  // while pending, the clearing read wins over a new event; a lasting condition re-raises it the next cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_pending <= 1'b0;
    end else if (new_irq) begin
      irq_pending <= 1'b1;
    end else if (clear_read) begin
      irq_pending <= 1'b0;
    end
  end

  // flags accumulate conditions of enabled inputs until a clearing read with none active; bus writes never touch them
  always_ff @(posedge core_clk) begin
    if (srst) begin
      interrupt_flags <= `IOC_RST_ZERO;
    end else if (any_condition) begin
      interrupt_flags <= interrupt_flags | condition;
    end else if (clear_read) begin
      interrupt_flags <= `IOC_RST_ZERO;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      interrupt_capture <= `IOC_RST_ZERO;
    end else if (new_irq) begin
      interrupt_capture <= port_level_bits;
    end
  end

  // previous-value reference reloads from the synchronised pins every cycle, whether a change is reported or not
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reference <= `IOC_RST_ZERO;
    end else begin
      reference <= pin_sync;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pullup_enable <= `IOC_RST_ZERO;
      output_latch <= `IOC_RST_ZERO;
    end else begin
      if (wr_pullup) begin
        pullup_enable <= reg_wdata;
      end
      if (wr_latch) begin
        output_latch <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= `IOC_RST_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        `IOC_ADDR_PULLUP: reg_rdata <= pullup_enable;
        `IOC_ADDR_FLAGS: reg_rdata <= interrupt_flags;
        `IOC_ADDR_CAPTURE: reg_rdata <= interrupt_capture;
        `IOC_ADDR_PORT: reg_rdata <= port_level_bits;
        `IOC_ADDR_LATCH: reg_rdata <= output_latch;
        default: reg_rdata <= `IOC_RST_ZERO;
      endcase
    end
  end

  assign pin_out = output_latch;
  assign pin_oe = ~is_input;
  assign pin_pullup = pullup_enable & is_input;
  // open-drain pulls low when active; push-pull drives the chosen level
  assign irq_out = open_drain ? 1'b0 : (irq_pending ~^ active_high);
  assign irq_oe = open_drain ? irq_pending : 1'b1;
endmodule : ioc_port
`default_nettype wire

// file: logic/ioc_params.svh
// Functional notes
// - pull-up on a pin only when its pull-up bit is 1 and pin is input.
// - flag bit sets only for enabled pins whose condition caused the interrupt; here conditions arising while pending also set flags.
// - interrupt flag register is read-only; writes leave it unchanged.
// - while pending, flags keep updating but the capture register holds.
// - on interrupt, capture pin levels; hold until capture or port read.
// - port register read returns pin levels with per-pin inversion applied.
// - port register write stores the byte into the output latch.
// - output latch read returns latch contents, not pin levels.
// - output pins are driven from latch bits; input pins are not driven.
// - only input pins can cause interrupts or flags.
// - interrupt stays active until capture or port read; writes never clear it.
// - only the first event loads capture; no new interrupt until cleared.
// - previous-value mode interrupts on change; new level becomes the reference.
// - default mode interrupts while pin differs from default, even after reads.
// - interrupt pin asserts while interrupt active, with configured drive and level.
// - direction bit 1 means input, 0 means output.
// - polarity bit 1 reports inverted pin level in the port register.
// - compare-mode bit 1 compares to default, 0 to previous value.
// - open-drain select overrides polarity; else polarity 1 high, 0 low.
`ifndef IOC_PARAMS_SVH
`define IOC_PARAMS_SVH
`define IOC_ADDR_DIRECTION 8'h00
`define IOC_ADDR_INVERSION 8'h01
`define IOC_ADDR_IRQ_ENABLE 8'h02
`define IOC_ADDR_DEFAULT 8'h03
`define IOC_ADDR_MODE 8'h04
`define IOC_ADDR_CONFIG 8'h05
`define IOC_ADDR_PULLUP 8'h06
`define IOC_ADDR_FLAGS 8'h07
`define IOC_ADDR_CAPTURE 8'h08
`define IOC_ADDR_PORT 8'h09
`define IOC_ADDR_LATCH 8'h0A
`define IOC_CFG_OPEN_DRAIN 2
`define IOC_CFG_ACTIVE_HIGH 1
`define IOC_RST_ZERO 8'h00
`define IOC_RST_DIRECTION 8'hFF
`endif

// file: logic/ioc_pkg.sv
package ioc_pkg;
  typedef logic [7:0] ioc_byte_t;
endpackage : ioc_pkg

// file: logic/ioc_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser, one per pin
module ioc_sync (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] async_in,
  output logic [7:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      logic meta;
      always_ff @(posedge core_clk) begin
        if (srst) begin
          meta <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta <= async_in[i];
          sync_out[i] <= meta;
        end
      end
    end
  endgenerate
endmodule : ioc_sync
`default_nettype wire

// file: sim/ioc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// pad resolution: device drive where enabled, else the external source
module ioc_pin_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : ioc_pin_model
`default_nettype wire

// file: sim/ioc_port_props.sv
`timescale 1ns/10ps
`default_nettype none
module ioc_port_props (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] pin_direction,
  input wire logic [7:0] change_irq_enable,
  input wire logic [7:0] expander_config,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic irq_out,
  input wire logic irq_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  wire act = expander_config[2] ? irq_oe : (irq_oe && irq_out == expander_config[1]);
  wire clr = reg_rd && (reg_addr == 8'h08 || reg_addr == 8'h09);
  wire lw = reg_wr && (reg_addr == 8'h09 || reg_addr == 8'h0A);
  sequence s_no_src;
    !act && (pin_direction & change_irq_enable) == 8'h00;
  endsequence
  AST_DRIVE: assert property (pin_oe == ~pin_direction)
    else $error("pin enable does not follow direction");
  AST_WRITE: assert property (lw |=> pin_out == $past(reg_wdata))
    else $error("latch write lost");
  AST_KEEP: assert property (!lw |=> $stable(pin_out))
    else $error("latch changed without a write");
  AST_LATCH_READ: assert property (reg_rd && reg_addr == 8'h0A |=> reg_rdata == $past(pin_out))
    else $error("latch read wrong");
  AST_HOLD: assert property (act && !clr |=> act)
    else $error("interrupt dropped without a clearing read");
  AST_OPEN_DRAIN: assert property (expander_config[2] |-> !(irq_oe && irq_out))
    else $error("open drain pin driven high");
  AST_PUSH_PULL: assert property (!expander_config[2] |-> irq_oe)
    else $error("push pull pin not driven");
  AST_QUIET: assert property (s_no_src [*4] |=> !act)
    else $error("interrupt without an input source");
endmodule : ioc_port_props
bind ioc_port ioc_port_props checker_i (.*);
`default_nettype wire

// file: sim/io_port_interrupt_on_change_tb.sv
`timescale 1ns/10ps
`default_nettype none
module io_port_interrupt_on_change_tb;
  logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq_out, irq_oe;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, pin_in, pin_out, pin_oe;
  logic [7:0] pin_direction = 8'hFF, input_inversion = 8'h00, change_irq_enable = 8'h00;
  logic [7:0] default_compare_value = 8'h00, compare_mode_select = 8'h00;
  logic [7:0] expander_config = 8'h00, ext_level = 8'h20, pin_pullup;
  int failures = 0, checks = 0;
  ioc_port DUT (.*);
  ioc_pin_model pins (.pin_out, .pin_oe, .ext_level, .pin_in);
  always #2.5 core_clk = ~core_clk;
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask : cmp
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk) reg_rd <= 1'b0;
    #1 cmp(reg_rdata, e);
  endtask : rd
  task results;
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  initial begin
    #5000;
    failures++;
    results();
  end
  initial begin
    tick(2);
    srst <= 1'b0;
    rd(8'h06, 8'h00);
    wr(8'h06, 8'hFF);
    @(posedge core_clk) pin_direction <= 8'hF0;
    wr(8'h09, 8'hA5);
    cmp(pin_pullup, 8'hF0);
    rd(8'h0A, 8'hA5);
    cmp(pin_out, 8'hA5);
    cmp(pin_oe, 8'h0F);
    @(posedge core_clk) {input_inversion, expander_config} <= {8'h11, 8'h02};
    rd(8'h09, 8'h34);
    @(posedge core_clk) change_irq_enable <= 8'hFF;
    @(posedge core_clk) ext_level <= 8'h30;
    tick(6);
    cmp({7'h00, irq_out}, 8'h01);
    @(posedge core_clk) ext_level <= 8'h70;
    tick(6);
    wr(8'h07, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h0A, 8'h0A);
    rd(8'h07, 8'h50);
    cmp(pin_out, 8'h0A);
    cmp({7'h00, irq_out}, 8'h01);
    rd(8'h08, 8'h24);
    tick(2);
    cmp({7'h00, irq_out}, 8'h00);
    @(posedge core_clk) {compare_mode_select, default_compare_value} <= {8'hFF, 8'h70};
    tick(6);
    cmp({7'h00, irq_out}, 8'h00);
    @(posedge core_clk) default_compare_value <= 8'h60;
    tick(6);
    rd(8'h09, 8'h6B);
    tick(2);
    cmp({7'h00, irq_out}, 8'h01);
    @(posedge core_clk) expander_config <= 8'h04;
    #1 cmp({6'h00, irq_oe, irq_out}, 8'h02);
    @(posedge core_clk) default_compare_value <= 8'h70;
    tick(6);
    rd(8'h09, 8'h6B);
    tick(2);
    cmp({7'h00, irq_oe}, 8'h00);
    results();
  end
endmodule : io_port_interrupt_on_change_tb
`default_nettype wire
